// ### rtl/ssr_pkg.sv
// Constants shared by the serial readout block and its synchroniser
package ssr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int WORD_W = 16;
	localparam int CNT_W  = 8;
	localparam int BIT_W  = 5;

	////////////////////////////////////////////////////////////////////////////
	// Timing, in nanoseconds as specified, then in reference clock cycles
	localparam int CLK_NS      = 10;
	localparam int START_NS    = 270;
	localparam int SCLK_NS     = 110;
	localparam int CONV_NS     = 2200;
	localparam int START_CYC   = (START_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCLK_CYC    = SCLK_NS / CLK_NS;
	localparam int SCLK_HI_CYC = SCLK_CYC / 2;
	localparam int SCLK_LO_CYC = SCLK_CYC - SCLK_HI_CYC;
	localparam int CONV_CYC    = CONV_NS / CLK_NS;
	localparam int NUM_BITS    = 16;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and format constants
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [WORD_W-1:0] SIGN_FLIP = 16'h8000;

endpackage

// ### rtl/ssr_sync.sv
// Two-stage level synchroniser for signals entering a clock domain
module ssr_sync
	import ssr_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset of the receiving domain
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule

// ### rtl/ssr_readout.sv
// Conversion control and serial result output of the sampling converter
module ssr_readout
	import ssr_pkg::*;
(
	// Reference clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              resetn_i,
	// Host control pins
	input  wire logic              cs_n_i,
	input  wire logic              rd_conv_i,
	input  wire logic              clock_source_select_i,
	input  wire logic              output_format_select_i,
	input  wire logic              power_down_i,
	input  wire logic              tag_i,
	// Result of the successive approximation core, straight binary
	input  wire logic [WORD_W-1:0] raw_code_i,
	// Serial clock pin: external clock in, internal clock out
	input  wire logic              serial_clock_pin_i,
	output logic                   serial_clock_pin_o,
	output logic                   serial_clock_pin_oe_o,
	// Serial data, sync pulse and busy
	output logic                   data_o,
	output logic                   sync_o,
	output logic                   busy_n_o
);

	typedef enum logic [0:0] {CV_IDLE, CV_RUN} ssr_conv_e;
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_HIGH, TX_LOW} ssr_tx_e;

	// Straight binary to two's complement differs only in the sign bit
	function automatic logic [WORD_W-1:0] fmt_word(input logic [WORD_W-1:0] w,
		input logic straight);
		fmt_word = straight ? w : (w ^ SIGN_FLIP);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers in the reference domain
	logic [5:0] pins_s;
	logic       cs_n_s, rc_s, ext_s, fmt_s, pd_s, tag_s;

	ssr_sync #(.W(6)) u_pin_sync (
		.clk_i    (ref_clk_i),
		.resetn_i (resetn_i),
		.async_i  ({cs_n_i, rd_conv_i, clock_source_select_i,
		            output_format_select_i, power_down_i, tag_i}),
		.sync_o   (pins_s)
	);

	assign {cs_n_s, rc_s, ext_s, fmt_s, pd_s, tag_s} = pins_s;

	////////////////////////////////////////////////////////////////////////////
	// Convert command: the two controls are ORed, start on the later fall
	logic cmd_n_r;
	logic start;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_n_r <= 1'b0; // Synchronisers reset low: release must not look like a fall
		end else begin
			cmd_n_r <= cs_n_s | rc_s;
		end
	end

	ssr_conv_e             cv_state_r;
	logic [CNT_W-1:0]      cv_cnt_r;
	logic [WORD_W-1:0]     result_r;
	logic                  res_tgl_r;

	// Power down inhibits starts; a start during a conversion is ignored
	assign start = cmd_n_r & ~(cs_n_s | rc_s) & ~pd_s & (cv_state_r == CV_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// Conversion timer, busy and result latch
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cv_state_r <= CV_IDLE;
			cv_cnt_r   <= '0;
			busy_n_o   <= 1'b1;
			result_r   <= WORD_RST;
			res_tgl_r  <= 1'b0;
		end else begin
			case (cv_state_r)
				CV_IDLE: begin
					if (start) begin
						cv_state_r <= CV_RUN;
						cv_cnt_r   <= CNT_W'(CONV_CYC - 1);
						busy_n_o   <= 1'b0;
					end
				end
				CV_RUN: begin
					if (cv_cnt_r == '0) begin
						// Latch and release busy together, never past the limit
						cv_state_r <= CV_IDLE;
						busy_n_o   <= 1'b1;
						result_r   <= fmt_word(raw_code_i, fmt_s);
						res_tgl_r  <= ~res_tgl_r;
					end else begin
						cv_cnt_r <= cv_cnt_r - 1'b1;
					end
				end
				default: begin
					cv_state_r <= CV_IDLE;
					busy_n_o   <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Internal clock transmission of the previous result
	ssr_tx_e           tx_state_r;
	logic [CNT_W-1:0]  tx_cnt_r;
	logic [BIT_W-1:0]  tx_bits_r;
	logic [WORD_W-1:0] tx_sr_r;
	logic              tx_tag_r;
	logic              int_data_r;
	logic              int_sclk_r;

	// The word is taken at start, before this conversion can overwrite it
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_state_r <= TX_IDLE;
			tx_cnt_r   <= '0;
			tx_bits_r  <= '0;
			tx_sr_r    <= WORD_RST;
			tx_tag_r   <= 1'b0;
			int_data_r <= 1'b0;
			int_sclk_r <= 1'b0;
		end else begin
			case (tx_state_r)
				TX_IDLE: begin
					int_sclk_r <= 1'b0;
					if (start && !ext_s) begin
						tx_state_r <= TX_WAIT;
						tx_cnt_r   <= CNT_W'(START_CYC - 1);
						tx_sr_r    <= {result_r[WORD_W-2:0], 1'b0};
						int_data_r <= result_r[WORD_W-1];
						tx_tag_r   <= tag_s;
						tx_bits_r  <= '0;
					end
				end
				TX_WAIT: begin
					if (tx_cnt_r == '0) begin
						tx_state_r <= TX_HIGH;
						tx_cnt_r   <= CNT_W'(SCLK_HI_CYC - 1);
						int_sclk_r <= 1'b1;
					end else begin
						tx_cnt_r <= tx_cnt_r - 1'b1;
					end
				end
				TX_HIGH: begin
					if (tx_cnt_r == '0) begin
						int_sclk_r <= 1'b0;
						tx_bits_r  <= tx_bits_r + 1'b1;
						tx_cnt_r   <= CNT_W'(SCLK_LO_CYC - 1);
						if (tx_bits_r == BIT_W'(NUM_BITS - 1)) begin
							tx_state_r <= TX_IDLE;
							int_data_r <= tx_tag_r;
						end else begin
							tx_state_r <= TX_LOW;
							int_data_r <= tx_sr_r[WORD_W-1];
							tx_sr_r    <= {tx_sr_r[WORD_W-2:0], 1'b0};
						end
					end else begin
						tx_cnt_r <= tx_cnt_r - 1'b1;
					end
				end
				TX_LOW: begin
					if (tx_cnt_r == '0) begin
						tx_state_r <= TX_HIGH;
						tx_cnt_r   <= CNT_W'(SCLK_HI_CYC - 1);
						int_sclk_r <= 1'b1;
					end else begin
						tx_cnt_r <= tx_cnt_r - 1'b1;
					end
				end
				default: begin
					tx_state_r <= TX_IDLE;
					int_sclk_r <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read state level handed to the link domain from a flop
	logic rd_state_r;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_state_r <= 1'b0;
		end else begin
			rd_state_r <= ext_s & ~cs_n_s & rc_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link domain on the external serial clock
	logic [2:0]        lnk_s;
	logic              l_rd, l_ext, l_tgl;
	logic              l_seen_r, l_pend_r, l_sync_r, l_data_r;
	logic [WORD_W-1:0] l_sr_r;

	ssr_sync #(.W(3)) u_link_sync (
		.clk_i    (serial_clock_pin_i),
		.resetn_i (resetn_i),
		.async_i  ({rd_state_r, ext_s, res_tgl_r}),
		.sync_o   (lnk_s)
	);

	assign {l_rd, l_ext, l_tgl} = lnk_s;

	// A new word is only loaded outside reads; the toggle lags the word,
	// so the word is settled when the change is seen
	always_ff @(posedge serial_clock_pin_i or negedge resetn_i) begin
		if (!resetn_i) begin
			l_seen_r <= 1'b0;
			l_pend_r <= 1'b0;
			l_sync_r <= 1'b0;
			l_data_r <= 1'b0;
			l_sr_r   <= WORD_RST;
		end else begin
			l_sync_r <= 1'b0;
			if (!l_rd || !l_ext) begin
				l_pend_r <= l_ext;
				if (l_tgl != l_seen_r) begin
					l_seen_r <= l_tgl;
					l_sr_r   <= result_r;
				end
			end else if (l_pend_r) begin
				l_pend_r <= 1'b0;
				l_sync_r <= 1'b1;
			end else begin
				l_data_r <= l_sr_r[WORD_W-1];
				l_sr_r   <= {l_sr_r[WORD_W-2:0], tag_i};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs; the mode select is static during operation
	assign serial_clock_pin_o    = int_sclk_r;
	assign serial_clock_pin_oe_o = ~ext_s;
	assign data_o                = ext_s ? l_data_r : int_data_r;
	assign sync_o                = l_sync_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [BIT_W-1:0] pulse_cnt_r;

	// Counts internal clock falls since the last start
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pulse_cnt_r <= '0;
		end else if (start) begin
			pulse_cnt_r <= '0;
		end else if (int_sclk_r && tx_cnt_r == '0 && tx_state_r == TX_HIGH) begin
			pulse_cnt_r <= pulse_cnt_r + 1'b1;
		end
	end

	sequence s_sclk_high;
		serial_clock_pin_o [*5];
	endsequence

	sequence s_sclk_low;
		!serial_clock_pin_o [*6];
	endsequence

	AST_FORMAT: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(busy_n_o) |-> result_r == ($past(raw_code_i) ^ ($past(fmt_s) ? 16'h0000 : 16'h8000)))
		else $error("result format does not follow select");
	AST_BUSY_MAX: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$fell(busy_n_o) |-> ##[1:220] busy_n_o)
		else $error("busy low too long");
	AST_BUSY_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$fell(busy_n_o) |-> !busy_n_o [*8] ##1 $stable(result_r))
		else $error("busy released early or result changed");
	AST_START: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		start |=> !busy_n_o && cv_state_r == CV_RUN)
		else $error("conversion did not start");
	AST_FIRST_CLK: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		start && !ext_s |=> !serial_clock_pin_o [*8] ##20 $rose(serial_clock_pin_o))
		else $error("internal clock start delay wrong");
	AST_PERIOD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(serial_clock_pin_o) && pulse_cnt_r < 5'd15 |-> s_sclk_high ##1 s_sclk_low
			##1 serial_clock_pin_o)
		else $error("internal clock period wrong");
	AST_PULSE_COUNT: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$fell(int_sclk_r) && tx_state_r == TX_IDLE |-> pulse_cnt_r == 5'd16)
		else $error("internal clock pulse count wrong");
	AST_IDLE_LOW: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		tx_state_r == TX_IDLE && !start |=> !serial_clock_pin_o)
		else $error("internal clock not low between conversions");
	AST_MSB_FIRST: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		start && !ext_s |=> int_data_r == $past(result_r[WORD_W-1]))
		else $error("first bit is not the MSB");
	AST_SYNC_PULSE: assert property (@(posedge serial_clock_pin_i) disable iff (!resetn_i)
		l_sync_r |-> $past(l_pend_r) && l_rd ##1 !l_sync_r)
		else $error("sync pulse without idle clock");
	AST_TAG_PASS: assert property (@(posedge serial_clock_pin_i) disable iff (!resetn_i)
		l_rd && l_ext && !l_pend_r |=> l_sr_r[0] == $past(tag_i))
		else $error("tag not shifted into chain");

endmodule

// ### tb/ssr_host_model.sv
// Host model: external serial clock and tag source
module ssr_host_model (
	// Link side
	output logic      link_clk_o,
	output logic      tag_o,
	input  wire logic data_i,
	input  wire logic sync_i
);
	timeunit 1ns;
	timeprecision 100ps;

	logic idle_tag;

	// Clock stands low between frames
	initial begin
		link_clk_o = 1'b0;
		idle_tag = 1'b0;
		tag_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Static tag level, as the internal mode latches it at each start
	task set_tag(input logic v);
		idle_tag = v;
		tag_o = v;
	endtask

	// Frame of n pulses; 35 ns is the shortest legal period
	task frame(input int n, input logic tg, output logic [31:0] d, output logic [31:0] s);
		for (int i = 0; i < n; i++) begin
			tag_o = tg;
			#17.5 link_clk_o = 1'b1;
			#2 tag_o = ~tg; // Past hold time the line is not trusted
			#13 d[i] = data_i;
			s[i] = sync_i;
			#2.5 link_clk_o = 1'b0;
		end
		tag_o = idle_tag;
	endtask
endmodule

// ### tb/test_ssr_readout.sv
// Testbench for the serial readout block
module test_ssr_readout
	import ssr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic              ref_clk_i, resetn_i, cs_n, rd_conv, sel, fmt, pwd;
	logic [WORD_W-1:0] raw, last_res, w;
	logic              sck_o, sck_oe, data_o, sync_o, busy_n, link_clk, tag, pin;
	logic [31:0]       d, s;
	int                mismatches, cmp_count, k, n;

	// Reference clock
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// Pin level from whichever side drives it
	assign pin = sck_oe ? sck_o : link_clk;

	ssr_readout u_ssr_readout (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .rd_conv_i(rd_conv),
		.clock_source_select_i(sel), .output_format_select_i(fmt), .power_down_i(pwd),
		.tag_i(tag), .raw_code_i(raw), .serial_clock_pin_i(pin),
		.serial_clock_pin_o(sck_o), .serial_clock_pin_oe_o(sck_oe),
		.data_o(data_o), .sync_o(sync_o), .busy_n_o(busy_n));

	ssr_host_model u_ssr_host_model (.link_clk_o(link_clk), .tag_o(tag),
		.data_i(data_o), .sync_i(sync_o));

	////////////////////////////////////////////////////////////////////////////
	// Compare tasks and closing report
	task fail(input string m);
		mismatches++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task chk_bit(input logic g, input logic e, input string m);
		cmp_count++;
		if (g !== e) fail(m);
	endtask
	task chk_word(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e, input string m);
		cmp_count++;
		if (g !== e) fail(m);
	endtask
	task chk_int(input int g, input int lo, input int hi, input string m);
		cmp_count++;
		if (g < lo || g > hi) fail(m);
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Internal clock convert; the readout shows the previous result
	task automatic conv_int(input logic [15:0] r, input logic f, input logic tg);
		int bc = 0;
		int rises = 0;
		int first = 0;
		int last = 0;
		int per = 0;
		logic sck_d = 1'b0;
		raw <= r;
		fmt <= f;
		u_ssr_host_model.set_tag(tg);
		@(posedge ref_clk_i);
		rd_conv <= 1'b0;
		for (int i = 1; i <= 300; i++) begin
			@(posedge ref_clk_i);
			if (i == 4) rd_conv <= 1'b1;
			#1;
			bc += int'(busy_n === 1'b0);
			if (sck_o === 1'b1 && sck_d === 1'b0) begin
				if (rises > 0) per = i - last;
				else first = i;
				last = i;
				if (rises < 16) w[15 - rises] = data_o;
				rises++;
			end
			sck_d = sck_o;
		end
		chk_int(first, 28, 31, "clock start delay");
		chk_int(per, SCLK_CYC, SCLK_CYC, "clock period");
		chk_int(rises, NUM_BITS, NUM_BITS, "pulse count");
		chk_bit(sck_o, 1'b0, "clock idle level");
		chk_int(bc, CONV_CYC, CONV_CYC, "busy low time");
		chk_bit(busy_n, 1'b1, "busy released");
		chk_word(w, last_res, "word shifted out");
		last_res = f ? r : {~r[15], r[14:0]};
		$display("internal convert done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		resetn_i = 1'b0;
		cs_n = 1'b0;
		rd_conv = 1'b1;
		sel = 1'b0;
		fmt = 1'b1;
		pwd = 1'b0;
		raw = 16'h0000;
		last_res = 16'h0000;
		mismatches = 0;
		cmp_count = 0;
		repeat (5) @(posedge ref_clk_i);
		#1;
		chk_bit(busy_n, 1'b1, "busy in reset");
		chk_bit(sck_o, 1'b0, "clock in reset");
		@(posedge ref_clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		// Back-to-back converts in both formats
		conv_int(16'ha5c3, 1'b1, 1'b1);
		conv_int(16'h1234, 1'b0, 1'b0);
		// A start while powered down is ignored
		pwd <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		rd_conv <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		rd_conv <= 1'b1;
		repeat (40) @(posedge ref_clk_i);
		chk_bit(busy_n, 1'b1, "start while powered down");
		pwd <= 1'b0;
		$display("power down done");
		conv_int(16'h0f0f, 1'b1, 1'b1);
		// Second reset in mid-run, now with the external clock
		resetn_i <= 1'b0;
		sel <= 1'b1;
		cs_n <= 1'b1;
		raw <= 16'hc0de;
		repeat (6) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		chk_bit(sck_oe, 1'b0, "pin released");
		cs_n <= 1'b0;
		rd_conv <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		cs_n <= 1'b1;
		rd_conv <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end while (busy_n !== 1'b1 && n < 300);
		if (n >= 300) begin
			fail("busy timeout");
			give_verdict();
		end
		// Frames run only after busy rises, far from its edge
		u_ssr_host_model.frame(4, 1'b0, d, s);
		@(posedge ref_clk_i);
		cs_n <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
		u_ssr_host_model.frame(24, 1'b1, d, s);
		k = 99;
		for (int i = 3; i >= 0; i--) if (s[i] === 1'b1) k = i;
		chk_int(k, 0, 3, "sync pulse");
		chk_bit(s[k + 1], 1'b0, "sync one period");
		for (int i = 0; i < 16; i++) w[15 - i] = d[k + 1 + i];
		chk_word(w, 16'hc0de, "external word");
		chk_bit(d[k + 17], 1'b1, "tag after word");
		$display("external read done");
		give_verdict();
	end
endmodule
